// ===== core/pcs_pkg.sv
/*
  Shared constants for the program-flow and data-pointer block: widths,
  register offsets, reset values and the program counter load sources.
  Assumes it is compiled before every other file of the block.
*/

// ************************************************************
// Program counter and stack pointer package
// ************************************************************
package pcs_pkg;

  // Data path widths.
  localparam int PC_W = 13;
  localparam int LOW_W = 8;
  localparam int LATCH_W = 5;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int JUMP_W = 11;
  localparam int IND_ADDR_W = 9;
  localparam int STACK_DEPTH = 8;

  // Register offsets on the software port.
  localparam logic [ADDR_W-1:0] OFF_INDIRECT = 7'h00;
  localparam logic [ADDR_W-1:0] OFF_PC_LOW = 7'h02;
  localparam logic [ADDR_W-1:0] OFF_POINTER = 7'h04;
  localparam logic [ADDR_W-1:0] OFF_HIGH_LATCH = 7'h0a;
  localparam logic [ADDR_W-1:0] OFF_BANK = 7'h0c;

  // Field positions.
  localparam int JUMP_LATCH_LSB = 3;
  localparam int BANK_BIT = 0;

  // Reset values and fixed answers.
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [LATCH_W-1:0] LATCH_RESET = 5'h00;
  localparam logic [DATA_W-1:0] POINTER_RESET = 8'h00;
  localparam logic BANK_RESET = 1'b0;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
  localparam logic [PC_W-1:0] INT_VECTOR_DEFAULT = 13'h0004;

  // Where the next program counter value comes from.
  typedef enum {
    PCS_LOAD_STEP,
    PCS_LOAD_HOLD,
    PCS_LOAD_LOW_WRITE,
    PCS_LOAD_JUMP,
    PCS_LOAD_CALL,
    PCS_LOAD_RETURN,
    PCS_LOAD_VECTOR
  } pcs_load_e;

  // True when an indirect address points back at the indirect location.
  function automatic logic pcsIsSelfRef(input logic [IND_ADDR_W-1:0] a);
    pcsIsSelfRef = (a[ADDR_W-1:0] == OFF_INDIRECT);
  endfunction

endpackage

// ===== core/pcs_return_stack.sv
/*
  Eight-entry circular return stack for the program counter.
  Assumes push and pop never arrive in the same cycle; the pointer is
  not visible to software and there is no overflow indication.
*/
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Return stack
// ************************************************************
module pcs_return_stack import pcs_pkg::*; #(
  parameter int DEPTH = STACK_DEPTH,
  parameter int WIDTH = PC_W
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Stack movement.
  input wire logic pushEn,
  input wire logic [WIDTH-1:0] pushValue,
  input wire logic popEn,
  // Most recent entry.
  output logic [WIDTH-1:0] topValue
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] entry_reg [DEPTH];
  logic [PTR_W-1:0] ptr_reg;
  logic [PTR_W-1:0] topIdx;

  // The entry below the pointer is the last one pushed.
  assign topIdx = PTR_W'(ptr_reg - 1'b1);
  assign topValue = entry_reg[topIdx];

  // circular overwrite wrap.
  // The pointer simply wraps, so a ninth push lands on the first slot.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ptr_reg <= '0;
    end else if (pushEn) begin
      ptr_reg <= PTR_W'(ptr_reg + 1'b1);
    end else if (popEn) begin
      ptr_reg <= topIdx;
    end
  end

  // eight entry storage.
  // Entries are cleared at reset so a stray pop returns a known value.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        entry_reg[i] <= '0;
      end
    end else if (pushEn) begin
      entry_reg[ptr_reg] <= pushValue;
    end
  end

endmodule
`default_nettype wire

// ===== core/pcs_indirect_port.sv
/*
  File select pointer, bank select bit and indirect access to data memory.
  Assumes data memory answers reads combinationally for the address that
  this module drives, and takes a write on the cycle its strobe is high.
*/
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Indirect data port
// ************************************************************
module pcs_indirect_port import pcs_pkg::*; (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port.
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWrStb,
  // Data memory.
  input wire logic [DATA_W-1:0] dataMemRdData,
  output logic [IND_ADDR_W-1:0] dataMemAddr,
  output logic dataMemWrStb,
  output logic [DATA_W-1:0] dataMemWrData,
  // Readback.
  output logic [DATA_W-1:0] pointerValue,
  output logic bankValue,
  output logic [DATA_W-1:0] indReadValue
);

  logic [DATA_W-1:0] fileSelectPointer_reg;
  logic indirectBankSelect_reg;
  logic dataMemWrStb_reg;
  logic [DATA_W-1:0] dataMemWrData_reg;
  logic selfRef;

  // nine bit address.
  // The bank bit sits above the eight pointer bits.
  assign dataMemAddr = {indirectBankSelect_reg, fileSelectPointer_reg};
  assign selfRef = pcsIsSelfRef(dataMemAddr);
  assign pointerValue = fileSelectPointer_reg;
  assign bankValue = indirectBankSelect_reg;
  assign dataMemWrStb = dataMemWrStb_reg;
  assign dataMemWrData = dataMemWrData_reg;

  // self read zero.
  // The pointer aimed at the indirect location reads back as zero.
  assign indReadValue = selfRef ? READ_ZERO : dataMemRdData;

  // Pointer and bank bit are plain software registers.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fileSelectPointer_reg <= POINTER_RESET;
      indirectBankSelect_reg <= BANK_RESET;
    end else if (regWrStb) begin
      if (regAddr == OFF_POINTER) begin
        fileSelectPointer_reg <= regWrData;
      end
      if (regAddr == OFF_BANK) begin
        indirectBankSelect_reg <= regWrData[BANK_BIT];
      end
    end
  end

  // self write dropped.
  // The strobe goes out one cycle late, while the address still holds.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dataMemWrStb_reg <= 1'b0;
      dataMemWrData_reg <= READ_ZERO;
    end else begin
      dataMemWrStb_reg <= regWrStb && (regAddr == OFF_INDIRECT) && !selfRef;
      dataMemWrData_reg <= regWrData;
    end
  end

endmodule
`default_nettype wire

// ===== core/pcs_top.sv
/*
  Program counter, high-part latch, return stack and indirect addressing
  of a small 8-bit core, with a plain register port for software.
  Assumes the instruction decoder raises at most one flow request a cycle
  and that writes on the register port come from executing instructions.
*/
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Thirteen-bit program counter, low byte visible, upper five bits hidden.
// - Any reset clears the whole program counter.
// - Writing the low byte loads upper bits from latch bits four to zero.
// - Jump or call takes eleven operand bits plus latch bits four, three.
// - Low-byte arithmetic wraps in eight bits; no carry to upper bits.
// - Eight entries of thirteen bits, pointer hidden from software.
// - Call and interrupt push; all three returns pop.
// - Push and pop leave the high-part latch alone.
// - Stack is circular; ninth push overwrites the first.
// - No overflow flags and no explicit push or pop.
// - Indirect location accesses data memory at the pointer.
// - Pointer at the indirect location reads zero.
// - Indirect write to itself stores nothing.
// - Indirect address is bank bit above eight pointer bits.
// - High-part latch is five bits, reset to zero.

// ************************************************************
// Top level
// ************************************************************
module pcs_top import pcs_pkg::*; #(
  parameter logic [PC_W-1:0] INT_VECTOR = INT_VECTOR_DEFAULT
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port.
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [DATA_W-1:0] regRdData,
  // Flow requests from the decoder.
  input wire logic stepEn,
  input wire logic jumpEn,
  input wire logic callEn,
  input wire logic retEn,
  input wire logic intVecEn,
  input wire logic [JUMP_W-1:0] opTarget,
  // Program memory address.
  output logic [PC_W-1:0] progAddr,
  // Data memory.
  output logic [IND_ADDR_W-1:0] dataMemAddr,
  output logic dataMemWrStb,
  output logic [DATA_W-1:0] dataMemWrData,
  input wire logic [DATA_W-1:0] dataMemRdData
);

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [PC_W-1:0] pc_reg;
  logic [PC_W-1:0] pc_next;
  logic [LATCH_W-1:0] pcHighLatch_reg;
  logic [DATA_W-1:0] regRdData_reg;
  logic [DATA_W-1:0] readMux;
  logic [PC_W-1:0] pcPlusOne;
  logic [PC_W-1:0] stackTop;
  logic [PC_W-1:0] pushValue;
  logic pushEn;
  logic popEn;
  logic lowByteWrite;
  logic latchWrite;
  logic [DATA_W-1:0] pointerValue;
  logic bankValue;
  logic [DATA_W-1:0] indReadValue;
  pcs_load_e loadSel;

  // Decoded register writes.
  assign lowByteWrite = regWrStb && (regAddr == OFF_PC_LOW);
  assign latchWrite = regWrStb && (regAddr == OFF_HIGH_LATCH);
  assign pcPlusOne = PC_W'(pc_reg + 1'b1);

  // ************************************************************
  // Program counter
  // ************************************************************

  // Pick the load source. Interrupt vectoring outranks every instruction
  // request, so a late interrupt never loses its return address.
  always_comb begin
    if (intVecEn) begin
      loadSel = PCS_LOAD_VECTOR;
    end else if (retEn) begin
      loadSel = PCS_LOAD_RETURN;
    end else if (callEn) begin
      loadSel = PCS_LOAD_CALL;
    end else if (jumpEn) begin
      loadSel = PCS_LOAD_JUMP;
    end else if (lowByteWrite) begin
      loadSel = PCS_LOAD_LOW_WRITE;
    end else if (stepEn) begin
      loadSel = PCS_LOAD_STEP;
    end else begin
      loadSel = PCS_LOAD_HOLD;
    end
  end

  // Next program counter value for each source.
  always_comb begin
    case (loadSel)
      PCS_LOAD_STEP: pc_next = pcPlusOne;
      PCS_LOAD_HOLD: pc_next = pc_reg;
      // eight bit wrap.
      // The written byte is taken as is; software advances the latch.
      PCS_LOAD_LOW_WRITE: pc_next = {pcHighLatch_reg, regWrData};
      PCS_LOAD_JUMP, PCS_LOAD_CALL: begin
        pc_next = {pcHighLatch_reg[LATCH_W-1:JUMP_LATCH_LSB], opTarget};
      end
      PCS_LOAD_RETURN: pc_next = stackTop;
      PCS_LOAD_VECTOR: pc_next = INT_VECTOR;
      default: pc_next = pc_reg;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pc_reg <= PC_RESET;
    end else begin
      pc_reg <= pc_next;
    end
  end

  assign progAddr = pc_reg;

  // ************************************************************
  // High-part latch
  // ************************************************************

  // stack leaves latch.
  // Only a software write touches the latch; stack traffic never does.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pcHighLatch_reg <= LATCH_RESET;
    end else if (latchWrite) begin
      pcHighLatch_reg <= regWrData[LATCH_W-1:0];
    end
  end

  // ************************************************************
  // Return stack
  // ************************************************************

  // implicit movement only.
  // A call saves the following instruction; an interrupt saves the one
  // it preempted. There is no status output for overflow on purpose.
  assign pushEn = (loadSel == PCS_LOAD_VECTOR) || (loadSel == PCS_LOAD_CALL);
  assign popEn = (loadSel == PCS_LOAD_RETURN);
  assign pushValue = (loadSel == PCS_LOAD_VECTOR) ? pc_reg : pcPlusOne;

  pcs_return_stack #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(PC_W)
  ) u_stack (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pushEn(pushEn),
    .pushValue(pushValue),
    .popEn(popEn),
    .topValue(stackTop)
  );

  // ************************************************************
  // Indirect addressing
  // ************************************************************

  pcs_indirect_port u_indirect (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrStb(regWrStb),
    .dataMemRdData(dataMemRdData),
    .dataMemAddr(dataMemAddr),
    .dataMemWrStb(dataMemWrStb),
    .dataMemWrData(dataMemWrData),
    .pointerValue(pointerValue),
    .bankValue(bankValue),
    .indReadValue(indReadValue)
  );

  // ************************************************************
  // Register readback
  // ************************************************************

  // Read selection; unmapped offsets answer zero.
  always_comb begin
    case (regAddr)
      OFF_INDIRECT: readMux = indReadValue;
      OFF_PC_LOW: readMux = pc_reg[LOW_W-1:0];
      OFF_POINTER: readMux = pointerValue;
      OFF_HIGH_LATCH: readMux = {{(DATA_W-LATCH_W){1'b0}}, pcHighLatch_reg};
      OFF_BANK: readMux = {{(DATA_W-1){1'b0}}, bankValue};
      default: readMux = READ_ZERO;
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      regRdData_reg <= READ_ZERO;
    end else if (regRdStb) begin
      regRdData_reg <= readMux;
    end else begin
      regRdData_reg <= READ_ZERO;
    end
  end

  assign regRdData = regRdData_reg;

  // ************************************************************
  // Assertions
  // ************************************************************

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic flowIdle;
  assign flowIdle = !intVecEn && !retEn && !callEn && !jumpEn;

  a_reset_clears_pc: assert property (
    $rose(rst_n) |-> progAddr == PC_RESET
  ) else $error("Program counter not zero after reset.");

  a_low_write_loads: assert property (
    flowIdle && lowByteWrite
    |=> progAddr == {$past(pcHighLatch_reg), $past(regWrData)}
  ) else $error("Low byte write did not load the full counter.");

  a_jump_loads_pc: assert property (
    jumpEn && !intVecEn && !retEn && !callEn
    |=> progAddr[JUMP_W-1:0] == $past(opTarget)
        && progAddr[PC_W-1:JUMP_W] == $past(pcHighLatch_reg[LATCH_W-1:JUMP_LATCH_LSB])
  ) else $error("Jump target formed wrongly.");

  a_step_adds_one: assert property (
    flowIdle && !lowByteWrite && stepEn
    |=> progAddr == PC_W'($past(progAddr) + 1'b1)
  ) else $error("Sequential step did not add one.");

  a_call_then_return: assert property (
    (callEn && !intVecEn && !retEn) ##1 (retEn && !intVecEn)
    |=> progAddr == PC_W'($past(progAddr, 2) + 1'b1)
  ) else $error("Return did not resume after the call.");

  a_vector_then_return: assert property (
    intVecEn ##1 (retEn && !intVecEn) |=> progAddr == $past(progAddr, 2)
  ) else $error("Return from interrupt lost the preempted address.");

  a_latch_kept: assert property (
    (callEn || retEn || intVecEn) && !latchWrite |=> $stable(pcHighLatch_reg)
  ) else $error("Stack movement changed the high-part latch.");

  a_low_byte_read: assert property (
    regRdStb && regAddr == OFF_PC_LOW |=> regRdData == $past(progAddr[LOW_W-1:0])
  ) else $error("Low byte readback wrong.");

  a_self_read_zero: assert property (
    regRdStb && regAddr == OFF_INDIRECT && pcsIsSelfRef(dataMemAddr)
    |=> regRdData == READ_ZERO
  ) else $error("Self indirect read not zero.");

  a_self_write_nop: assert property (
    regWrStb && regAddr == OFF_INDIRECT && pcsIsSelfRef(dataMemAddr)
    |=> !dataMemWrStb
  ) else $error("Self indirect write reached memory.");

  a_indirect_write: assert property (
    regWrStb && regAddr == OFF_INDIRECT && !pcsIsSelfRef(dataMemAddr)
    |=> dataMemWrStb && dataMemWrData == $past(regWrData)
        && dataMemAddr == $past(dataMemAddr)
  ) else $error("Indirect write not passed to memory.");

  a_read_one_cycle: assert property (
    !regRdStb |=> regRdData == READ_ZERO
  ) else $error("Read data stood outside its cycle.");

  c_call_return: cover property (callEn ##1 retEn);
  c_interrupt: cover property (intVecEn ##1 stepEn);
  c_low_write: cover property (flowIdle && lowByteWrite);
  c_self_read: cover property (
    regRdStb && regAddr == OFF_INDIRECT && pcsIsSelfRef(dataMemAddr)
  );

endmodule
`default_nettype wire

// ===== tb/pcs_data_mem.sv
/*
  Data memory model that faces the indirect port: 512 bytes.
  Assumes reads must answer combinationally and writes land on the
  edge that samples the write strobe.
*/
`timescale 1ns/1ps
`default_nettype none

// ********
// Data memory model
// ********
module pcs_data_mem import pcs_pkg::*; (
  // Clock.
  input wire logic core_clk,
  // Memory port.
  input wire logic [IND_ADDR_W-1:0] dataMemAddr,
  input wire logic dataMemWrStb,
  input wire logic [DATA_W-1:0] dataMemWrData,
  output logic [DATA_W-1:0] dataMemRdData
);
  logic [DATA_W-1:0] mem [0:511];

  // A known fill, so an untouched location never reads as unknown.
  initial begin
    for (int i = 0; i < 512; i++) begin
      mem[i] = 8'h5a ^ i[7:0];
    end
  end

  // Writes are taken only on a strobed edge.
  always @(posedge core_clk) begin
    if (dataMemWrStb) begin
      mem[dataMemAddr] <= dataMemWrData;
    end
  end

  // Reads answer at once for the driven address.
  assign dataMemRdData = mem[dataMemAddr];
endmodule
`default_nettype wire

// ===== tb/program_counter_stack_indirect_bench.sv
/*
  Self-checking bench for the program counter, return stack and indirect
  port. Assumes the design package is compiled first and the data memory
  model sits on the memory side.
*/
`timescale 1ns/1ps
`default_nettype none

// ********
// Bench top
// ********
module program_counter_stack_indirect_bench import pcs_pkg::*; ;
  localparam logic [PC_W-1:0] IVEC = 13'h0123;
  localparam int LIMIT = 6000;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] regAddr = 7'h00;
  logic [DATA_W-1:0] regWrData = 8'h00;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic stepEn = 1'b0;
  logic jumpEn = 1'b0;
  logic callEn = 1'b0;
  logic retEn = 1'b0;
  logic intVecEn = 1'b0;
  logic [JUMP_W-1:0] opTarget = 11'h000;
  logic [DATA_W-1:0] regRdData, dataMemWrData, dataMemRdData;
  logic [PC_W-1:0] progAddr;
  logic [IND_ADDR_W-1:0] dataMemAddr;
  logic dataMemWrStb;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  int sp;
  logic [31:0] seed = 32'd51;
  logic [PC_W-1:0] expPc;
  logic [PC_W-1:0] stk [8];
  logic [4:0] expLatch;

  pcs_top #(.INT_VECTOR(IVEC)) dut (.core_clk, .rst_n, .regAddr, .regWrData, .regWrStb,
    .regRdStb, .regRdData, .stepEn, .jumpEn, .callEn, .retEn, .intVecEn, .opTarget,
    .progAddr, .dataMemAddr, .dataMemWrStb, .dataMemWrData, .dataMemRdData);
  pcs_data_mem mem (.core_clk, .dataMemAddr, .dataMemWrStb, .dataMemWrData, .dataMemRdData);

  // Free-running clock at 20 MHz.
  always #25 core_clk = ~core_clk;

  // Cycle ceiling, so a hang still reaches the verdict.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      end_sim();
    end
  end

  // Repeatable xorshift source.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Jump destination: latch bits four and three above the operand.
  function automatic logic [PC_W-1:0] jumpDest(input logic [4:0] l, input logic [10:0] t);
    return {l[4:3], t};
  endfunction

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // The bench's picture of the block after any reset.
  task automatic resetModel();
    expPc = 13'h0000;
    expLatch = 5'h00;
    sp = 0;
    foreach (stk[i]) stk[i] = 13'h0000;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge core_clk);
    regWrStb <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge core_clk);
    regRdStb <= 1'b0;
    #1;
    d = regRdData;
  endtask

  // One flow request, driven at an edge and taken at the next one. It stands until the
  // next call replaces it, so requests follow back to back; each call checks the counter
  // left by the request before it. Code 4'hf is idle and must end a run of requests.
  // Flag order: stepEn, jumpEn, callEn, retEn, intVecEn, regWrStb.
  task automatic doOp(input logic [3:0] op, input logic [31:0] v);
    logic [PC_W-1:0] jd;
    logic [PC_W-1:0] prev;
    logic [5:0] f;
    logic [3:0] w;
    jd = jumpDest(expLatch, v[10:0]);
    prev = expPc;
    w = op;
    case (op)
      4'd0: f = 6'b100000;
      4'd1: f = 6'b010000;
      4'd2: f = 6'b001000;
      4'd3: f = 6'b000100;
      4'd4: f = 6'b000010;
      4'd5: f = 6'b100001;
      4'd6: f = 6'b000001;
      // Several requests in one cycle: only the highest ranked one may act.
      4'd7: begin
        f = 6'b111111;
        w = 4'd4;
      end
      4'd8: begin
        f = 6'b011101;
        w = 4'd3;
      end
      4'd9: begin
        f = 6'b111001;
        w = 4'd2;
      end
      4'd10: begin
        f = 6'b110001;
        w = 4'd1;
      end
      default: f = 6'b000000;
    endcase
    @(posedge core_clk);
    opTarget <= v[10:0];
    regWrData <= v[7:0];
    regAddr <= (op == 4'd6) ? OFF_HIGH_LATCH : OFF_PC_LOW;
    {stepEn, jumpEn, callEn, retEn, intVecEn, regWrStb} <= f;
    #1;
    chk("progAddr", 16'(progAddr), 16'(prev));
    case (w)
      4'd0: expPc = expPc + 13'h0001;
      4'd1: expPc = jd;
      4'd2: begin
        stk[sp] = expPc + 13'h0001;
        sp = (sp + 1) % 8;
        expPc = jd;
      end
      4'd3: begin
        sp = (sp + 7) % 8;
        expPc = stk[sp];
      end
      4'd4: begin
        stk[sp] = expPc;
        sp = (sp + 1) % 8;
        expPc = IVEC;
      end
      4'd5: expPc = {expLatch, v[7:0]};
      4'd6: expLatch = v[4:0];
      default: ;
    endcase
  endtask

  // Main sequence.
  initial begin
    logic [7:0] rdv;
    logic [7:0] p;
    logic [31:0] v;
    logic b;
    logic self;
    resetModel();
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    chk("progAddr", 16'(progAddr), 16'h0000);
    rd(OFF_HIGH_LATCH, rdv);
    chk("latch", 16'(rdv), 16'h0000);
    doOp(4'd6, 32'hff);
    doOp(4'hf, 32'h0);
    rd(OFF_HIGH_LATCH, rdv);
    chk("latch", 16'(rdv), 16'h001f);
    $display("reset and latch test done");
    // A computed jump: the byte wraps and the upper bits stay with the latch.
    doOp(4'd6, 32'h03);
    doOp(4'd5, 32'hff);
    doOp(4'hf, 32'h0);
    rd(OFF_PC_LOW, rdv);
    chk("pcLow", 16'(rdv), 16'h00ff);
    p = rdv + 8'h01;
    doOp(4'd5, {24'h000000, p});
    doOp(4'd5, 32'hff);
    doOp(4'd0, 32'h0);
    doOp(4'hf, 32'h0);
    rd(OFF_PC_LOW, rdv);
    chk("pcLow", 16'(rdv), 16'h0000);
    $display("low byte test done");
    for (int i = 0; i < 10; i++) doOp(4'd2, rnd());
    for (int i = 0; i < 10; i++) doOp(4'd3, 32'h0);
    // Interrupt then return, then requests that clash in one cycle.
    doOp(4'd4, 32'h0);
    doOp(4'd3, 32'h0);
    doOp(4'd9, rnd());
    doOp(4'd8, 32'h0);
    doOp(4'd7, 32'h0);
    doOp(4'd8, 32'h0);
    doOp(4'd10, rnd());
    doOp(4'hf, 32'h0);
    rd(OFF_HIGH_LATCH, rdv);
    chk("latch", 16'(rdv), 16'(expLatch));
    $display("stack wrap test done");
    repeat (300) begin
      v = rnd();
      doOp(v[31:28], rnd());
      doOp(v[27:24], rnd());
      doOp(4'hf, 32'h0);
      rd(OFF_PC_LOW, rdv);
      chk("pcLow", 16'(rdv), 16'(expPc[7:0]));
    end
    $display("random flow test done");
    for (int i = 0; i < 24; i++) begin
      v = rnd();
      p = (i == 0) ? 8'h00 : (i == 1) ? 8'h80 : v[7:0];
      b = (i == 1) ? 1'b1 : v[8];
      self = (p[6:0] == 7'h00);
      wr(OFF_POINTER, p);
      wr(OFF_BANK, {7'h00, b});
      chk("dataMemAddr", 16'(dataMemAddr), 16'({b, p}));
      wr(OFF_INDIRECT, v[23:16]);
      chk("dataMemWrStb", 16'(dataMemWrStb), 16'(!self));
      chk("dataMemWrData", 16'(dataMemWrData), 16'(v[23:16]));
      rd(OFF_INDIRECT, rdv);
      chk("indirect", 16'(rdv), 16'(self ? 8'h00 : v[23:16]));
    end
    wr(7'h7f, 8'ha5);
    rd(7'h7f, rdv);
    chk("unmapped", 16'(rdv), 16'h0000);
    $display("indirect test done");
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    resetModel();
    chk("progAddr", 16'(progAddr), 16'h0000);
    doOp(4'd3, 32'h0);
    doOp(4'hf, 32'h0);
    rd(OFF_HIGH_LATCH, rdv);
    chk("latch", 16'(rdv), 16'h0000);
    $display("second reset test done");
    end_sim();
  end
endmodule
`default_nettype wire
